// ==== verilog/cmfc_pkg.sv ====
package cmfc_pkg;
  // input-voltage hold threshold code: 4.2 V + code * 100 mV, 4.2..4.9 V
  localparam int unsigned HOLD_BASE_MV = 4200;
  localparam int unsigned HOLD_STEP_MV = 100;
  localparam logic [2:0] HOLD_CODE_MAX = 3'h7;
  // termination register code: 500 uA steps, 37 mA ceiling
  localparam logic [6:0] TERM_CODE_MAX = 7'h4a;
  localparam logic [6:0] TERM_CODE_DEFAULT = 7'h14;
  // termination resistor selection, percent of fast-charge current
  localparam logic [1:0] TERM_SEL_5 = 2'h0;
  localparam logic [1:0] TERM_SEL_10 = 2'h1;
  localparam logic [1:0] TERM_SEL_15 = 2'h2;
  localparam logic [1:0] TERM_SEL_20 = 2'h3;
  localparam logic [4:0] PCT_5 = 5'h05;
  localparam logic [4:0] PCT_10 = 5'h0a;
  localparam logic [4:0] PCT_15 = 5'h0f;
  localparam logic [4:0] PCT_20 = 5'h14;
  // interrupt pulse timing
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned PULSE_US = 128;
  localparam int unsigned PULSE_CYCLES = PULSE_US * CLK_MHZ;
  localparam int unsigned PULSE_W = 12;
  // fault field encodings
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_OVP = 2'h1;
  localparam logic [1:0] FAULT_LOCKOUT = 2'h2;
  // charge phases
  typedef enum logic [1:0] {
    CMFC_IDLE,
    CMFC_CC,
    CMFC_CV,
    CMFC_DONE
  } cmfc_phase_t;
endpackage

// ==== verilog/cmfc_pulse.sv ====
`timescale 1ns/10ps
`default_nettype none
module cmfc_pulse (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // trigger
  input wire logic fire_in,
  // output pulse
  output logic pulse_out
);
  logic [cmfc_pkg::PULSE_W-1:0] count_q;

  // one-shot: count down from the pulse length, retrigger ignored while busy
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count_q <= '0;
    end else if (fire_in && count_q == '0) begin
      count_q <= cmfc_pkg::PULSE_W'(cmfc_pkg::PULSE_CYCLES);
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // registered pulse, high for exactly the pulse length
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (fire_in && count_q == '0) || count_q > 1;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/cmfc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module cmfc_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // analog comparator pins (asynchronous)
  input wire logic in_above_lockout_in,
  input wire logic in_above_sleep_in,
  input wire logic in_overvoltage_in,
  input wire logic in_above_hold_in,
  input wire logic battery_present_in,
  input wire logic bat_at_regulation_in,
  input wire logic current_at_termination_in,
  input wire logic bat_above_recharge_in,
  input wire logic node_below_entry_offset_in,
  input wire logic node_above_exit_offset_in,
  input wire logic input_limit_active_in,
  input wire logic charge_disable_pin_in,
  input wire logic program_pin_grounded_in,
  input wire logic [1:0] termination_program_sel_in,
  // deglitch done strobes from analog timers (asynchronous levels)
  input wire logic ovp_deglitched_in,
  input wire logic lockout_deglitched_in,
  // host control bits
  input wire logic host_write_in,
  input wire logic host_reset_bit_in,
  input wire logic hold_enable_in,
  input wire logic [2:0] hold_code_in,
  input wire logic double_timer_in,
  input wire logic charge_disable_bit_in,
  input wire logic termination_enable_in,
  input wire logic [6:0] term_code_in,
  input wire logic fault_read_in,
  // status and control outputs
  output logic input_voltage_limit_flag_out,
  output logic [2:0] input_voltage_hold_threshold_out,
  output logic hold_loop_enabled_out,
  output logic timer_extend_out,
  output logic discharge_switch_on_out,
  output logic charge_fet_on_out,
  output logic [1:0] phase_out,
  output logic supplement_out,
  output logic default_mode_out,
  output logic use_register_defaults_out,
  output logic [4:0] term_percent_out,
  output logic [6:0] term_code_out,
  output logic [6:0] precharge_code_out,
  output logic [1:0] fault_out,
  output logic charge_done_out,
  output logic interrupt_out
);
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] raw_in, sync1_q, sync2_q;
  logic [1:0] sel1_q, sel2_q;
  logic in_lock, in_sleep, in_ovp, in_hold, bat_p, at_reg, at_term, above_rech;
  logic node_lo, node_hi, input_limit_program_pin_act, cd_pin, grounded, ovp_dg, lock_dg;
  logic hold_active, input_valid, charge_allowed, term_ok;
  logic ovp_prev_q, lock_prev_q, fire;
  cmfc_pkg::cmfc_phase_t phase_q;

  assign raw_in = {in_above_lockout_in, in_above_sleep_in, in_overvoltage_in, in_above_hold_in,
                   battery_present_in, bat_at_regulation_in, current_at_termination_in,
                   bat_above_recharge_in, node_below_entry_offset_in, node_above_exit_offset_in,
                   input_limit_active_in, charge_disable_pin_in, program_pin_grounded_in,
                   ovp_deglitched_in, lockout_deglitched_in};

  // two-stage synchronisers for every pin
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sel1_q <= '0;
      sel2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      // resistor selection bus rides the same two stages
      sel1_q <= termination_program_sel_in;
      sel2_q <= sel1_q;
    end
  end

  assign {in_lock, in_sleep, in_ovp, in_hold, bat_p, at_reg, at_term, above_rech,
          node_lo, node_hi, input_limit_program_pin_act, cd_pin, grounded, ovp_dg, lock_dg} = sync2_q;

  // percent of fast-charge current from the resistor selection
  function automatic logic [4:0] sel_percent(input logic [1:0] sel);
    case (sel)
      cmfc_pkg::TERM_SEL_5: sel_percent = cmfc_pkg::PCT_5;
      cmfc_pkg::TERM_SEL_10: sel_percent = cmfc_pkg::PCT_10;
      cmfc_pkg::TERM_SEL_15: sel_percent = cmfc_pkg::PCT_15;
      default: sel_percent = cmfc_pkg::PCT_20;
    endcase
  endfunction

  // termination register code limited to the 37 mA ceiling
  function automatic logic [6:0] term_clamp(input logic [6:0] code);
    if (code > cmfc_pkg::TERM_CODE_MAX) begin
      term_clamp = cmfc_pkg::TERM_CODE_MAX;
    end else begin
      term_clamp = code;
    end
  endfunction

  // hold loop regulating when enabled and input sags below threshold
  assign hold_active = hold_loop_enabled_out && in_lock && !in_hold;
  // valid input window for starting a charge cycle
  assign input_valid = in_lock && in_sleep && !in_ovp && (in_hold || !hold_loop_enabled_out);
  // both bit and pin must allow charge
  assign charge_allowed = input_valid && !charge_disable_bit_in && !cd_pin && bat_p;
  // termination only with voltage loop alone in control
  assign term_ok = termination_enable_in && !hold_active && !input_limit_program_pin_act && !supplement_out;

  // hold loop off at reset, host may enable once supply present
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hold_loop_enabled_out <= 1'b0;
      input_voltage_hold_threshold_out <= '0;
    end else if (host_write_in && (in_lock || bat_p)) begin
      // write taken only with supply or battery present
      hold_loop_enabled_out <= hold_enable_in;
      // top code is the 4.9 V threshold
      input_voltage_hold_threshold_out <= (hold_code_in > cmfc_pkg::HOLD_CODE_MAX) ?
                                          cmfc_pkg::HOLD_CODE_MAX : hold_code_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      input_voltage_limit_flag_out <= 1'b0;
      timer_extend_out <= 1'b0;
    end else begin
      input_voltage_limit_flag_out <= hold_active;
      timer_extend_out <= double_timer_in && hold_active;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase_q <= cmfc_pkg::CMFC_IDLE;
    end else begin
      case (phase_q)
        cmfc_pkg::CMFC_IDLE: begin
          // resume once input and enables allow
          if (charge_allowed) phase_q <= cmfc_pkg::CMFC_CC;
        end
        cmfc_pkg::CMFC_CC: begin
          if (!charge_allowed) phase_q <= cmfc_pkg::CMFC_IDLE;
          else if (at_reg) phase_q <= cmfc_pkg::CMFC_CV;
        end
        cmfc_pkg::CMFC_CV: begin
          if (!charge_allowed) phase_q <= cmfc_pkg::CMFC_IDLE;
          else if (term_ok && at_term && above_rech) phase_q <= cmfc_pkg::CMFC_DONE;
        end
        cmfc_pkg::CMFC_DONE: begin
          if (!charge_allowed) phase_q <= cmfc_pkg::CMFC_IDLE;
        end
        default: phase_q <= cmfc_pkg::CMFC_IDLE;
      endcase
    end
  end

  // charge fet and discharge switch drive
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      charge_fet_on_out <= 1'b0;
      discharge_switch_on_out <= 1'b0;
      phase_out <= '0;
      charge_done_out <= 1'b0;
    end else begin
      // fet conducts in current or voltage phase
      charge_fet_on_out <= charge_allowed && (phase_q == cmfc_pkg::CMFC_CC || phase_q == cmfc_pkg::CMFC_CV);
      // battery feeds node when input unusable
      discharge_switch_on_out <= in_ovp || (bat_p && !input_valid) || supplement_out;
      phase_out <= phase_q;
      charge_done_out <= phase_q == cmfc_pkg::CMFC_DONE;
    end
  end

  // supplement hysteresis between entry and exit offsets
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      supplement_out <= 1'b0;
    end else if (node_lo) begin
      // node below battery by entry offset
      supplement_out <= 1'b1;
    end else if (node_hi) begin
      // node above battery by exit offset
      supplement_out <= 1'b0;
    end
  end

  // default mode entry on valid supply or reset bit, exit on write
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      default_mode_out <= 1'b1;
      ovp_prev_q <= 1'b0;
    end else if (host_reset_bit_in || (input_valid && !ovp_prev_q)) begin
      default_mode_out <= 1'b1;
      ovp_prev_q <= input_valid;
    end else begin
      // any host write leaves default mode
      if (host_write_in) default_mode_out <= 1'b0;
      ovp_prev_q <= input_valid;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      use_register_defaults_out <= 1'b0;
      term_percent_out <= cmfc_pkg::PCT_10;
      term_code_out <= cmfc_pkg::TERM_CODE_DEFAULT;
      precharge_code_out <= cmfc_pkg::TERM_CODE_DEFAULT;
    end else begin
      use_register_defaults_out <= default_mode_out && grounded;
      term_percent_out <= sel_percent(sel2_q);
      if (default_mode_out) begin
        term_code_out <= cmfc_pkg::TERM_CODE_DEFAULT;
        precharge_code_out <= cmfc_pkg::TERM_CODE_DEFAULT;
      end else begin
        term_code_out <= term_clamp(term_code_in);
        precharge_code_out <= term_clamp(term_code_in);
      end
    end
  end

  logic ovp_seen_q;
  logic ovp_onset, lock_onset;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ovp_seen_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      ovp_seen_q <= in_ovp;
      lock_prev_q <= lock_dg;
    end
  end
  assign ovp_onset = in_ovp && !ovp_seen_q;
  assign lock_onset = lock_dg && !lock_prev_q;
  assign fire = ovp_onset || lock_onset;

  // fault latched; new fault wins over read, clear needs recovery
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      fault_out <= cmfc_pkg::FAULT_NONE;
    end else if (ovp_onset) begin
      fault_out <= cmfc_pkg::FAULT_OVP;
    end else if (lock_onset) begin
      fault_out <= cmfc_pkg::FAULT_LOCKOUT;
    end else if (fault_read_in && !in_ovp && !ovp_dg && !lock_dg) begin
      fault_out <= cmfc_pkg::FAULT_NONE;
    end
  end

  cmfc_pulse u_pulse (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .fire_in(fire),
    .pulse_out(interrupt_out)
  );
endmodule
`default_nettype wire

// ==== verification/cmfc_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module cmfc_monitor (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // watched inputs
  input wire logic in_overvoltage_in,
  input wire logic charge_disable_bit_in,
  input wire logic charge_disable_pin_in,
  input wire logic fault_read_in,
  input wire logic host_write_in,
  input wire logic host_reset_bit_in,
  // watched outputs
  input wire logic input_voltage_limit_flag_out,
  input wire logic default_mode_out,
  input wire logic [6:0] term_code_out,
  input wire logic [6:0] precharge_code_out,
  input wire logic [1:0] fault_out,
  input wire logic charge_done_out,
  input wire logic charge_fet_on_out,
  input wire logic discharge_switch_on_out,
  input wire logic interrupt_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic [11:0] hi_q;
  // length of the running interrupt pulse
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !interrupt_out) hi_q <= 12'h0000;
    else hi_q <= hi_q + 12'h0001;
  end
  // over-voltage seen through the synchroniser
  sequence s_ovp_held;
    $rose(in_overvoltage_in) ##1 in_overvoltage_in [*2];
  endsequence
  property p_ovp_fault;
    s_ovp_held |=> fault_out == cmfc_pkg::FAULT_OVP && discharge_switch_on_out;
  endproperty
  a_ovp_fault: assert property (p_ovp_fault) else $error("over-voltage fault not flagged");
  property p_pulse_len;
    $fell(interrupt_out) |-> hi_q == 12'h0c80;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("interrupt pulse length wrong");
  property p_fet_bit;
    charge_disable_bit_in [*5] |-> !charge_fet_on_out;
  endproperty
  a_fet_bit: assert property (p_fet_bit) else $error("charging with disable bit set");
  property p_fet_pin;
    charge_disable_pin_in [*5] |-> !charge_fet_on_out;
  endproperty
  a_fet_pin: assert property (p_fet_pin) else $error("charging with disable pin set");
  property p_fault_keep;
    fault_out != cmfc_pkg::FAULT_NONE && !fault_read_in && !$past(fault_read_in) |=> fault_out != cmfc_pkg::FAULT_NONE;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault cleared without read");
  property p_precharge;
    precharge_code_out == term_code_out;
  endproperty
  a_precharge: assert property (p_precharge) else $error("pre-charge differs from termination");
  property p_term_max;
    term_code_out <= cmfc_pkg::TERM_CODE_MAX;
  endproperty
  a_term_max: assert property (p_term_max) else $error("termination code above ceiling");
  property p_default_exit;
    host_write_in && !host_reset_bit_in |=> ##[0:2] !default_mode_out;
  endproperty
  a_default_exit: assert property (p_default_exit) else $error("default mode kept after write");
  property p_flag_noterm;
    input_voltage_limit_flag_out |-> !$rose(charge_done_out);
  endproperty
  a_flag_noterm: assert property (p_flag_noterm) else $error("terminated while hold loop active");
endmodule
bind cmfc_top cmfc_monitor u_mon (.*);
`default_nettype wire

// ==== verification/cmfc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cmfc_host_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // bench side
  input wire logic read_req_in,
  output logic [7:0] pulse_count_out,
  // device side
  input wire logic interrupt_in,
  output logic fault_read_out
);
  logic irq_q;
  // one read strobe per request
  always_ff @(posedge ref_clk_in) begin
    fault_read_out <= read_req_in && !reset_in;
  end
  always_ff @(posedge ref_clk_in) begin
    irq_q <= interrupt_in;
    if (reset_in) pulse_count_out <= 8'h00;
    else if (interrupt_in && !irq_q) pulse_count_out <= pulse_count_out + 8'h01;
  end
endmodule
`default_nettype wire

// ==== verification/test_charger_mode_fault_control.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_charger_mode_fault_control;
  logic ref_clk_in, reset_in, in_above_lockout_in, in_above_sleep_in, in_overvoltage_in, in_above_hold_in;
  logic battery_present_in, bat_at_regulation_in, current_at_termination_in, bat_above_recharge_in;
  logic node_below_entry_offset_in, node_above_exit_offset_in, input_limit_active_in, charge_disable_pin_in;
  logic program_pin_grounded_in, ovp_deglitched_in, lockout_deglitched_in, host_write_in, host_reset_bit_in;
  logic hold_enable_in, double_timer_in, charge_disable_bit_in, termination_enable_in, fault_read_in, read_req;
  logic [1:0] termination_program_sel_in, phase_out, fault_out;
  logic [2:0] hold_code_in, input_voltage_hold_threshold_out;
  logic [6:0] term_code_in, term_code_out, precharge_code_out;
  logic input_voltage_limit_flag_out, hold_loop_enabled_out, timer_extend_out, discharge_switch_on_out;
  logic charge_fet_on_out, supplement_out, default_mode_out, use_register_defaults_out, charge_done_out;
  logic interrupt_out;
  logic [4:0] term_percent_out;
  logic [7:0] pulses;
  int bad_count = 0;
  int n_tests = 0;
  cmfc_top DUT (.*);
  cmfc_host_model u_host (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .read_req_in(read_req),
    .pulse_count_out(pulses), .interrupt_in(interrupt_out), .fault_read_out(fault_read_in));
  // clock
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr();
    host_write_in <= 1'b1;
    step(1);
    host_write_in <= 1'b0;
    step(5);
  endtask
  task automatic rd();
    read_req <= 1'b1;
    step(1);
    read_req <= 1'b0;
    step(5);
  endtask
  task automatic test_done();
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    step(20000);
    bad_count++;
    test_done();
  end
  // main sequence
  initial begin
    {in_overvoltage_in, bat_at_regulation_in, current_at_termination_in, bat_above_recharge_in, read_req} = '0;
    {node_below_entry_offset_in, node_above_exit_offset_in, input_limit_active_in, charge_disable_pin_in} = '0;
    {program_pin_grounded_in, ovp_deglitched_in, lockout_deglitched_in, host_write_in, host_reset_bit_in} = '0;
    {hold_enable_in, hold_code_in, double_timer_in, charge_disable_bit_in, term_code_in} = '0;
    {in_above_lockout_in, in_above_sleep_in, in_above_hold_in, battery_present_in, termination_enable_in} = '1;
    termination_program_sel_in = cmfc_pkg::TERM_SEL_10;
    reset_in = 1'b1;
    step(6);
    reset_in <= 1'b0;
    step(1);
    chk(default_mode_out, 8'h01);
    chk(term_percent_out, 8'(cmfc_pkg::PCT_10));
    chk(precharge_code_out, 8'(cmfc_pkg::TERM_CODE_DEFAULT));
    chk(hold_loop_enabled_out, 8'h00);
    step(5);
    chk(phase_out, 8'(cmfc_pkg::CMFC_CC));
    for (int i = 0; i < 4; i++) begin
      charge_disable_bit_in <= (i == 0);
      charge_disable_pin_in <= (i == 2);
      step(6);
      chk(charge_fet_on_out, 8'(i % 2));
    end
    bat_at_regulation_in <= 1'b1;
    step(6);
    chk(phase_out, 8'(cmfc_pkg::CMFC_CV));
    {input_limit_active_in, current_at_termination_in, bat_above_recharge_in} <= 3'h7;
    step(6);
    chk(charge_done_out, 8'h00);
    input_limit_active_in <= 1'b0;
    step(6);
    chk(charge_done_out, 8'h01);
    chk(charge_fet_on_out, 8'h00);
    {hold_enable_in, hold_code_in, term_code_in} <= {4'hf, 7'h7f};
    wr();
    chk(default_mode_out, 8'h00);
    chk(input_voltage_hold_threshold_out, 8'h07);
    chk(hold_loop_enabled_out, 8'h01);
    chk(term_code_out, 8'(cmfc_pkg::TERM_CODE_MAX));
    chk(precharge_code_out, 8'(cmfc_pkg::TERM_CODE_MAX));
    {in_above_lockout_in, battery_present_in, hold_code_in} <= 5'h02;
    step(5);
    wr();
    chk(input_voltage_hold_threshold_out, 8'h07);
    {in_above_lockout_in, battery_present_in, double_timer_in} <= 3'h7;
    step(6);
    chk(default_mode_out, 8'h01);
    in_above_hold_in <= 1'b0;
    step(6);
    chk(input_voltage_limit_flag_out, 8'h01);
    chk(timer_extend_out, 8'h01);
    chk(charge_fet_on_out, 8'h00);
    chk(discharge_switch_on_out, 8'h01);
    in_above_hold_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      termination_program_sel_in <= 2'(i);
      step(6);
      chk(term_percent_out, 8'(5 * (i + 1)));
    end
    program_pin_grounded_in <= 1'b1;
    step(6);
    chk(use_register_defaults_out, 8'h01);
    wr();
    host_reset_bit_in <= 1'b1;
    step(1);
    host_reset_bit_in <= 1'b0;
    step(5);
    chk(default_mode_out, 8'h01);
    in_overvoltage_in <= 1'b1;
    step(4);
    chk(fault_out, 8'(cmfc_pkg::FAULT_OVP));
    chk(discharge_switch_on_out, 8'h01);
    chk(interrupt_out, 8'h01);
    step(3199);
    chk(interrupt_out, 8'h01);
    step(1);
    chk(interrupt_out, 8'h00);
    {in_overvoltage_in, ovp_deglitched_in} <= 2'h1;
    step(3);
    rd();
    chk(fault_out, 8'(cmfc_pkg::FAULT_OVP));
    ovp_deglitched_in <= 1'b0;
    step(3);
    rd();
    chk(fault_out, 8'(cmfc_pkg::FAULT_NONE));
    lockout_deglitched_in <= 1'b1;
    step(4);
    chk(fault_out, 8'(cmfc_pkg::FAULT_LOCKOUT));
    rd();
    chk(fault_out, 8'(cmfc_pkg::FAULT_LOCKOUT));
    lockout_deglitched_in <= 1'b0;
    step(3200);
    rd();
    chk(fault_out, 8'(cmfc_pkg::FAULT_NONE));
    chk(pulses, 8'h02);
    node_below_entry_offset_in <= 1'b1;
    charge_disable_bit_in <= 1'b1;
    step(6);
    chk(supplement_out, 8'h01);
    {node_below_entry_offset_in, charge_disable_bit_in} <= 2'h0;
    step(8);
    chk(supplement_out, 8'h01);
    chk(charge_done_out, 8'h00);
    node_above_exit_offset_in <= 1'b1;
    step(6);
    chk(supplement_out, 8'h00);
    chk(charge_done_out, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
